// >>> motor_brake_defines.svh
// Constants for the stop-braking control block
`ifndef MOTOR_BRAKE_DEFINES_SVH
`define MOTOR_BRAKE_DEFINES_SVH
// Register byte addresses
`define MB_ADDR_CTRL 12'h000
`define MB_ADDR_BRAKE 12'h004
`define MB_ADDR_REGEN 12'h008
`define MB_ADDR_TERM 12'h00C
`define MB_ADDR_STATUS 12'h010
`define MB_ADDR_FREQ 12'h014
`define MB_ADDR_DUTY 12'h018
// Reset values, limits and fixed codes of settings
`define MB_START_FREQ_RST 8'h03
`define MB_START_FREQ_MAX 8'h78
`define MB_DURATION_RST 7'h05
`define MB_DURATION_MAX 7'h64
`define MB_LEVEL_RST 5'h04
`define MB_LEVEL_MAX 5'h1E
`define MB_LEVEL_STD 5'h04
`define MB_LEVEL_CT 5'h02
`define MB_DUTY_LIMIT_RST 5'h00
`define MB_MOTOR_TYPE_RST 7'h03
`define MB_OE_FUNC_CODE 7'h0A
`define MB_ALARM_CODE_HI 7'h07
`define MB_ALARM_CODE_LO 7'h6B
`define MB_FIXED_DUTY_SMALL 5'h03
`define MB_FIXED_DUTY_LARGE 5'h02
`define MB_ALARM_PCT 8'h55
`define MB_TRIP_PCT 8'h64
// Time base: duration counts in 0.1 s steps
`define MB_TICK_NS 100000000
`define MB_CLK_NS 8
`endif

// >>> motor_brake_pkg.sv
// Types for the stop-braking control block
package motor_brake_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_INJECT, ST_COAST, ST_OFF} stop_state_t;
endpackage : motor_brake_pkg

// >>> motor_brake_stop_control.sv
// Stop-braking control: DC injection, regenerative duty, output enable
// Overview of operation
// - Inject DC when frequency reaches start frequency
// - Hold injection for programmed duration
// - Zero duration skips injection, motor coasts
// - Level 0-30 percent; zero means coast
// - Large model: 4 percent becomes 2 on CT
// - Large model: 2 percent becomes 4 on standard
// - Cap injection so current stays rated
// - Mode 0 uses fixed model duty
// - Mode 1 uses programmed duty limit
// - Alarm and indicator at 85 percent
// - Overvoltage fault at 100 percent
// - No panel indicator in mode 0
// - Alarm alone never stops output
// - Alarm terminal code 7 high, 107 low
// - Output off while enable input low
// - Enable bound by input code 10
// - Mode 2 unbound: stop input acts enable
// - Power failure coasts, then speed-search restart
//
// The APB slave port and the register offsets were left to the implementer.
`include "motor_brake_defines.svh"
`timescale 1ns/1ps
`default_nettype none
// Settings live here and are reached over APB with no wait states.
// Contact pins are synchronised; modulator status shares this clock.
module motor_brake_stop_control #(
  // Clock cycles in one tenth of a second
  parameter int TICK_CYCLES = `MB_TICK_NS / `MB_CLK_NS,
  // Largest models rewrite the level on a motor type change
  parameter bit LARGE_MODEL = 1'b0,
  // Small single-phase models use the higher fixed duty
  parameter bit SMALL_SINGLE = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Drive status from the modulator
  input wire logic decel_i,
  input wire logic stop_cmd_i,
  input wire logic [7:0] out_freq_i,
  input wire logic over_current_i,
  input wire logic regen_active_i,
  // Contact inputs from pins
  input wire logic [4:0] contact_in_i,
  input wire logic output_stop_input_i,
  // Drive outputs
  output logic dc_inject_o,
  output logic [4:0] dc_level_o,
  output logic gate_enable_o,
  output logic speed_search_o,
  output logic regen_duty_alarm_o,
  output logic duty_panel_indicator_o,
  output logic regen_overvoltage_fault_o,
  output logic [2:0] alarm_term_o
);

  // Pin synchronisers, two stages each
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;

  // Settings
  logic [7:0] start_freq_q;
  logic [6:0] duration_q;
  logic [4:0] level_q;
  logic [1:0] regen_mode_select_q;
  logic [4:0] regen_duty_limit_q;
  logic [6:0] motor_type_select_q;
  logic restart_enabled_q;
  // Terminal function tables: five inputs, three outputs
  logic [6:0] input_terminal_function_select_q [5];
  logic [6:0] output_terminal_function_select_q [3];
  logic fault_clear_q;

  // Runtime state
  motor_brake_pkg::stop_state_t state_q;
  logic [31:0] tick_cnt_q;
  logic [6:0] dur_cnt_q;
  // Wide enough for the trip point at the largest limit
  logic [19:0] duty_acc_q;
  logic [7:0] duty_pct_q;
  logic power_fail_q;

  // APB decode
  // Writes land at the access edge; reads are fetched at setup
  logic wr_en;
  logic rd_en;
  assign wr_en = psel_i & penable_i & pwrite_i;
  assign rd_en = psel_i & penable_i & ~pwrite_i;

  // Standard motor code check
  function automatic logic is_std(input logic [6:0] c);
    is_std = (c == 7'h00) || (c == 7'h03) || (c == 7'h17) || (c == 7'h28) || (c == 7'h2B);
  endfunction : is_std

  // Constant-torque motor code check
  function automatic logic is_ct(input logic [6:0] c);
    is_ct = (c == 7'h01) || (c == 7'h0D) || (c == 7'h32) || (c == 7'h35);
  endfunction : is_ct

  // Synchronise external pins
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pin_s1_q <= 6'h00;
      pin_s2_q <= 6'h00;
    end else begin
      // Stop pin in the top bit, contacts below
      pin_s1_q <= {output_stop_input_i, contact_in_i};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Find which contact carries output enable
  logic oe_bound;
  logic oe_level;
  always_comb begin
    // Default: nothing bound, enable held high
    oe_bound = 1'b0;
    oe_level = 1'b1;
    for (int i = 0; i < 5; i++) begin
      if (input_terminal_function_select_q[i] == `MB_OE_FUNC_CODE) begin
        oe_bound = 1'b1;
        oe_level = pin_s2_q[i];
      end
    end
    // Mode 2 with no binding: the stop pin stands in for enable
    if (!oe_bound && regen_mode_select_q == 2'd2) begin
      oe_bound = 1'b1;
      oe_level = pin_s2_q[5];
    end
  end

  // Enable low means ready lost; while running, in any mode, that is a power failure
  logic enable_ok;
  // Unbound outside mode 2, the stop pin halts the output and, while running, counts as a power failure
  assign enable_ok = oe_level & ~(~oe_bound & pin_s2_q[5]);

  // Register writes; motor type change rewrites level
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      // Reset loads the factory default of every setting
      start_freq_q <= `MB_START_FREQ_RST;
      duration_q <= `MB_DURATION_RST;
      level_q <= `MB_LEVEL_RST;
      regen_mode_select_q <= 2'h0;
      regen_duty_limit_q <= `MB_DUTY_LIMIT_RST;
      motor_type_select_q <= `MB_MOTOR_TYPE_RST;
      restart_enabled_q <= 1'b0;
      fault_clear_q <= 1'b0;
      for (int i = 0; i < 5; i++) input_terminal_function_select_q[i] <= 7'h00;
      for (int i = 0; i < 3; i++) output_terminal_function_select_q[i] <= 7'h00;
    end else begin
      // Clear request lasts one cycle only
      fault_clear_q <= 1'b0;
      if (wr_en) begin
        case (paddr_i)
          `MB_ADDR_CTRL: begin
            regen_mode_select_q <= pwdata_i[1:0];
            restart_enabled_q <= pwdata_i[2];
            fault_clear_q <= pwdata_i[3];
          end
          `MB_ADDR_BRAKE: begin
            // Clamp to settable ranges
            start_freq_q <= (pwdata_i[7:0] > `MB_START_FREQ_MAX) ?
              `MB_START_FREQ_MAX : pwdata_i[7:0];
            duration_q <= (pwdata_i[14:8] > `MB_DURATION_MAX) ?
              `MB_DURATION_MAX : pwdata_i[14:8];
            level_q <= (pwdata_i[20:16] > `MB_LEVEL_MAX) ?
              `MB_LEVEL_MAX : pwdata_i[20:16];
          end
          `MB_ADDR_REGEN: begin
            regen_duty_limit_q <= (pwdata_i[4:0] > `MB_LEVEL_MAX) ?
              `MB_LEVEL_MAX : pwdata_i[4:0];
            motor_type_select_q <= pwdata_i[14:8];
            // Old motor type against the new one decides the rewrite
            if (LARGE_MODEL && level_q == `MB_LEVEL_STD &&
                is_std(motor_type_select_q) && is_ct(pwdata_i[14:8]))
              level_q <= `MB_LEVEL_CT;
            else if (LARGE_MODEL && level_q == `MB_LEVEL_CT &&
                is_ct(motor_type_select_q) && is_std(pwdata_i[14:8]))
              level_q <= `MB_LEVEL_STD;
          end
          `MB_ADDR_TERM: begin
            for (int i = 0; i < 5; i++)
              input_terminal_function_select_q[i] <= {1'b0, pwdata_i[i*6 +: 6]};
            // Six-bit fields widened to the stored code width
          end
          `MB_ADDR_STATUS: begin
            for (int i = 0; i < 3; i++)
              output_terminal_function_select_q[i] <= pwdata_i[i*7 +: 7];
          end
          default: begin
            // Unmapped writes ignored
          end
        endcase
      end
    end
  end

  // Tenth-second tick
  // Held at zero outside injection so each run starts aligned
  logic tick;
  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || state_q != motor_brake_pkg::ST_INJECT) tick_cnt_q <= 32'h0000_0000;
    else if (tick) tick_cnt_q <= 32'h0000_0000;
    else tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
  end

  // Stop sequence state machine
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_q <= motor_brake_pkg::ST_RUN;
      dur_cnt_q <= 7'h00;
    end else begin
      case (state_q)
        motor_brake_pkg::ST_RUN: begin
          if (decel_i && stop_cmd_i && out_freq_i <= start_freq_q) begin
            // Zero time or zero level: skip straight to coasting
            if (duration_q == 7'h00 || level_q == 5'h00)
              state_q <= motor_brake_pkg::ST_COAST;
            else begin
              state_q <= motor_brake_pkg::ST_INJECT;
              dur_cnt_q <= duration_q;
            end
          end
        end
        motor_brake_pkg::ST_INJECT: begin
          // Count down whole tenths of a second
          if (tick) begin
            dur_cnt_q <= dur_cnt_q - 7'h01;
            if (dur_cnt_q == 7'h01) state_q <= motor_brake_pkg::ST_OFF;
          end
          // Lost enable during injection drops to coasting
          if (!enable_ok) state_q <= motor_brake_pkg::ST_COAST;
        end
        motor_brake_pkg::ST_COAST, motor_brake_pkg::ST_OFF: begin
          // Wait for a new run command
          if (!stop_cmd_i) state_q <= motor_brake_pkg::ST_RUN;
        end
        default: state_q <= motor_brake_pkg::ST_RUN;
      endcase
    end
  end

  // Effective duty limit by mode
  // Mode 2 behaves as mode 1: the programmed limit applies
  logic [4:0] eff_limit;
  always_comb begin
    if (regen_mode_select_q == 2'd0)
      eff_limit = SMALL_SINGLE ? `MB_FIXED_DUTY_SMALL : `MB_FIXED_DUTY_LARGE;
    else eff_limit = regen_duty_limit_q;
  end

  // Whole percent of the limit, before saturation
  logic [19:0] duty_quot;
  assign duty_quot = (duty_acc_q >> 8) / {15'h0000, eff_limit};

  // Duty accumulator: leaky counter of regen cycles per limit
  // Simplified model; real thermal integration is outside this block
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      duty_acc_q <= 16'h0000;
      duty_pct_q <= 8'h00;
    end else begin
      if (regen_active_i && duty_acc_q != 20'hF_FFFF)
        duty_acc_q <= duty_acc_q + 20'h0_0001;
      else if (!regen_active_i && duty_acc_q != 20'h0_0000)
        duty_acc_q <= duty_acc_q - 20'h0_0001;
      // Percent of limit: acc over 256, divided by limit (256 counts per percent per limit step)
      if (eff_limit == 5'h00) duty_pct_q <= 8'h00;
      // Saturate so a long overrun cannot wrap back below the trip
      else if (duty_quot > 20'h0_00FF) duty_pct_q <= 8'hFF;
      else duty_pct_q <= duty_quot[7:0];
    end
  end

  // Fault latches until cleared; set wins over clear
  // It removes the gate but leaves every setting intact
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) regen_overvoltage_fault_o <= 1'b0;
    else if (duty_pct_q >= `MB_TRIP_PCT && eff_limit != 5'h00)
      regen_overvoltage_fault_o <= 1'b1;
    else if (fault_clear_q) regen_overvoltage_fault_o <= 1'b0;
  end

  // Power failure in any mode coasts, restart with speed search
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      power_fail_q <= 1'b0;
      speed_search_o <= 1'b0;
    end else begin
      speed_search_o <= 1'b0;
      // Restart pulse lasts one cycle and needs restart enabled
      if (!enable_ok && state_q == motor_brake_pkg::ST_RUN) power_fail_q <= 1'b1;
      else if (enable_ok && power_fail_q) begin
        power_fail_q <= 1'b0;
        speed_search_o <= restart_enabled_q;
      end
    end
  end

  // Drive outputs, all registered
  logic alarm_now;
  assign alarm_now = (duty_pct_q >= `MB_ALARM_PCT) && eff_limit != 5'h00;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      dc_inject_o <= 1'b0;
      dc_level_o <= 5'h00;
      gate_enable_o <= 1'b0;
      regen_duty_alarm_o <= 1'b0;
      duty_panel_indicator_o <= 1'b0;
      alarm_term_o <= 3'h0;
    end else begin
      dc_inject_o <= (state_q == motor_brake_pkg::ST_INJECT) && enable_ok;
      // Back off level while current is over rating
      // Level forced to zero outside injection
      dc_level_o <= (state_q != motor_brake_pkg::ST_INJECT) ? 5'h00 :
        over_current_i ? (level_q >> 1) : level_q;
      // Alarm is not part of the gating term
      gate_enable_o <= enable_ok && !power_fail_q && !regen_overvoltage_fault_o &&
        (state_q == motor_brake_pkg::ST_RUN || state_q == motor_brake_pkg::ST_INJECT);
      regen_duty_alarm_o <= alarm_now;
      duty_panel_indicator_o <= alarm_now && regen_mode_select_q != 2'd0;
      // Each output terminal shows the alarm by its function code
      for (int i = 0; i < 3; i++) begin
        if (output_terminal_function_select_q[i] == `MB_ALARM_CODE_HI)
          alarm_term_o[i] <= alarm_now;
        else if (output_terminal_function_select_q[i] == `MB_ALARM_CODE_LO)
          alarm_term_o[i] <= ~alarm_now;
        // Terminals with other functions stay low
        else alarm_term_o[i] <= 1'b0;
      end
    end
  end

  // APB read and answer: zero wait, error on unmapped address
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      // Ready answers every setup in the following cycle
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      // Data latched at setup stands through the access cycle
      if (psel_i && !penable_i) begin
        case (paddr_i)
          `MB_ADDR_CTRL: prdata_o <= {29'h0, restart_enabled_q, regen_mode_select_q};
          `MB_ADDR_BRAKE: prdata_o <= {11'h0, level_q, 1'b0, duration_q, start_freq_q};
          `MB_ADDR_REGEN: prdata_o <= {17'h0, motor_type_select_q, 3'h0, regen_duty_limit_q};
          `MB_ADDR_STATUS: prdata_o <= {24'h0, oe_bound, enable_ok, power_fail_q,
            regen_overvoltage_fault_o, alarm_now, 1'b0, state_q};
          `MB_ADDR_DUTY: prdata_o <= {24'h0, duty_pct_q};
          `MB_ADDR_TERM, `MB_ADDR_FREQ: prdata_o <= 32'h0000_0000;
          // Unmapped addresses flag an error on read and on write
          default: pslverr_o <= 1'b1;
        endcase
      end
    end
  end

endmodule : motor_brake_stop_control
`default_nettype wire

// >>> motor_brake_stop_control_chk.sv
// Port-level checker for the stop-braking control block
`timescale 1ns/1ps
`default_nettype none
`include "motor_brake_defines.svh"
module motor_brake_stop_control_chk #(
  parameter int TICK_CYCLES = 10
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Drive outputs
  input wire logic dc_inject_o,
  input wire logic [4:0] dc_level_o,
  input wire logic speed_search_o,
  input wire logic regen_duty_alarm_o,
  input wire logic duty_panel_indicator_o
);
  // Longest legal injection plus a few cycles of tick alignment
  localparam int INJ_MAX = 100 * TICK_CYCLES + 4;
  logic [1:0] mode_q; // Mode as last written by software
  int inj_q; // Length of the current injection
  // Follow CTRL writes at their access edge
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mode_q <= 2'h0;
    end else if (psel_i && penable_i && pwrite_i && pready_o && paddr_i == `MB_ADDR_CTRL) begin
      mode_q <= pwdata_i[1:0];
    end
  end
  // Count injection cycles
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      inj_q <= 0;
    end else begin
      inj_q <= dc_inject_o ? inj_q + 1 : 0;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_access;
    psel_i && penable_i && pready_o;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> s_access)
    else $error("no ready in access cycle");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_slverr_unmapped: assert property (pslverr_o |-> pready_o &&
    (paddr_i[1:0] != 2'b00 || paddr_i > `MB_ADDR_DUTY))
    else $error("error response on a mapped address");
  a_inject_has_level: assert property (dc_inject_o |-> dc_level_o != 5'h00)
    else $error("injection with zero level");
  a_level_in_range: assert property (dc_level_o <= `MB_LEVEL_MAX)
    else $error("level above maximum");
  a_inject_bounded: assert property (inj_q <= INJ_MAX)
    else $error("injection too long");
  a_search_pulse: assert property ($rose(speed_search_o) |=> !speed_search_o)
    else $error("speed search not a pulse");
  a_panel_mode_zero: assert property (duty_panel_indicator_o |-> mode_q != 2'h0 || $past(mode_q) != 2'h0)
    else $error("indicator shown in mode zero");
  a_panel_with_alarm: assert property (duty_panel_indicator_o |-> regen_duty_alarm_o)
    else $error("indicator without alarm");
endmodule : motor_brake_stop_control_chk
bind motor_brake_stop_control motor_brake_stop_control_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk_sys_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
  .pslverr_o, .dc_inject_o, .dc_level_o, .speed_search_o, .regen_duty_alarm_o,
  .duty_panel_indicator_o);
`default_nettype wire

// >>> motor_far_side.sv
// Far-side model: motor speed ramp, regenerating load, converter ready
`timescale 1ns/1ps
`default_nettype none
module motor_far_side (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Scenario controls
  input wire logic decel_i,
  input wire logic regen_req_i,
  input wire logic pfail_i,
  // Towards the drive
  output logic [7:0] out_freq_o,
  output logic regen_active_o,
  output logic conv_ready_o
);
  // Speed drops 1 Hz a cycle while braking, else back at 60 Hz
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !decel_i) begin
      out_freq_o <= 8'h3C;
    end else if (out_freq_o != 8'h00) begin
      out_freq_o <= out_freq_o - 8'h01;
    end
  end
  // Load regenerates only when the scenario asks
  always_ff @(posedge clk_sys_i) begin
    regen_active_o <= rst_n_i && regen_req_i;
  end
  // Ready drops while the supply has failed
  always_ff @(posedge clk_sys_i) begin
    conv_ready_o <= rst_n_i && !pfail_i;
  end
endmodule : motor_far_side
`default_nettype wire

// >>> motor_brake_stop_control_tb.sv
// Self-checking bench for the stop-braking control block
`timescale 1ns/1ps
`default_nettype none
`include "motor_brake_defines.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
`define WAITF(c, n) begin k = 0; while (!(c) && k < n) begin @(posedge clk_sys_i); k++; end \
  if (!(c)) n_fail++; end
module motor_brake_stop_control_tb;
  localparam int TK = 10; // Short tick keeps the run brief
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic e; logic cd;} row_t;
  logic clk_sys_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic decel_i, stop_cmd_i, over_current_i, regen_active_i, output_stop_input_i;
  logic [7:0] out_freq_i;
  logic regen_req, pfail, conv_ready, seen, g0;
  logic dc_inject_o, gate_enable_o, speed_search_o, regen_duty_alarm_o;
  logic duty_panel_indicator_o, regen_overvoltage_fault_o;
  logic [4:0] dc_level_o;
  logic [2:0] alarm_term_o;
  int n_fail = 0, n_compared = 0, k;
  // Register cases: write or read, address, data, error, data checked
  row_t rows [12] = '{
    '{1'b0, `MB_ADDR_CTRL, 32'h0000_0000, 1'b0, 1'b1},
    '{1'b0, `MB_ADDR_BRAKE, 32'h0004_0503, 1'b0, 1'b1},
    '{1'b0, `MB_ADDR_REGEN, 32'h0000_0300, 1'b0, 1'b1},
    '{1'b0, 12'h01C, 32'h0000_0000, 1'b1, 1'b0},
    '{1'b1, 12'h01C, 32'h0000_1234, 1'b1, 1'b0},
    '{1'b1, `MB_ADDR_BRAKE, 32'h001E_6478, 1'b0, 1'b0},
    '{1'b0, `MB_ADDR_BRAKE, 32'h001E_6478, 1'b0, 1'b1},
    '{1'b1, `MB_ADDR_BRAKE, 32'h0004_0503, 1'b0, 1'b0},
    '{1'b1, `MB_ADDR_REGEN, 32'h0000_0D00, 1'b0, 1'b0},
    '{1'b0, `MB_ADDR_BRAKE, 32'h0002_0503, 1'b0, 1'b1},
    '{1'b1, `MB_ADDR_REGEN, 32'h0000_0300, 1'b0, 1'b0},
    '{1'b0, `MB_ADDR_BRAKE, 32'h0004_0503, 1'b0, 1'b1}};
  logic [31:0] zero_cfg [2] = '{32'h0008_000A, 32'h0000_020A}; // Zero time, zero level
  motor_brake_stop_control #(.TICK_CYCLES(TK), .LARGE_MODEL(1'b1), .SMALL_SINGLE(1'b0)) uut (
    .clk_sys_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .decel_i, .stop_cmd_i, .out_freq_i, .over_current_i,
    .regen_active_i, .contact_in_i({4'h0, conv_ready}), .output_stop_input_i, .dc_inject_o,
    .dc_level_o, .gate_enable_o, .speed_search_o, .regen_duty_alarm_o,
    .duty_panel_indicator_o, .regen_overvoltage_fault_o, .alarm_term_o);
  motor_far_side far (.clk_sys_i, .rst_n_i, .decel_i, .regen_req_i(regen_req), .pfail_i(pfail),
    .out_freq_o(out_freq_i), .regen_active_o(regen_active_i), .conv_ready_o(conv_ready));
  // Free-running system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // One APB transfer; request held until ready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    `WAITF(pready_o === 1'b1, 50)
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  // Reset for 12 cycles with all stimulus quiet
  task automatic reset_dut();
    @(posedge clk_sys_i);
    {decel_i, stop_cmd_i, over_current_i, output_stop_input_i, regen_req, pfail} <= '0;
    rst_n_i <= 1'b0;
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
  endtask : reset_dut
  task automatic close_out();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // Watchdog against a hung wait
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    n_fail++;
    close_out();
  end
  initial begin
    {rst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {decel_i, stop_cmd_i, over_current_i, output_stop_input_i, regen_req, pfail} = '0;
    reset_dut();
    @(posedge clk_sys_i);
    `CHK("reset outputs", 14'h0000, {dc_inject_o, dc_level_o, gate_enable_o, speed_search_o,
      regen_duty_alarm_o, duty_panel_indicator_o, regen_overvoltage_fault_o, alarm_term_o})
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      `CHK("pslverr", rows[i].e, err)
      if (rows[i].cd) `CHK("prdata", rows[i].d, rd)
    end
    $display("test registers done");
    // Injection: start, level, current cap, duration, then off
    apb(1'b1, `MB_ADDR_BRAKE, 32'h0008_020A);
    decel_i <= 1'b1;
    stop_cmd_i <= 1'b1;
    `WAITF(dc_inject_o === 1'b1, 200)
    `CHK("start freq", 1'b1, out_freq_i <= 8'h0A && out_freq_i >= 8'h06)
    `CHK("level", 5'h08, dc_level_o)
    k = 0;
    while (dc_inject_o === 1'b1 && k < 100) begin
      @(posedge clk_sys_i);
      k++;
      over_current_i <= (k >= 3 && k < 8);
      if (k == 6) `CHK("capped level", 5'h04, dc_level_o)
    end
    `CHK("duration", 1'b1, k >= TK && k <= 2 * TK + 3)
    repeat (3) @(posedge clk_sys_i);
    `CHK("stage off", 2'b00, {dc_inject_o, gate_enable_o})
    $display("test injection done");
    foreach (zero_cfg[i]) begin
      reset_dut();
      apb(1'b1, `MB_ADDR_BRAKE, zero_cfg[i]);
      decel_i <= 1'b1;
      stop_cmd_i <= 1'b1;
      seen = 1'b0;
      repeat (120) begin
        @(posedge clk_sys_i);
        seen = seen | dc_inject_o;
      end
      `CHK("no injection", 1'b0, seen)
    end
    $display("test coast done");
    // Converter ready on a bound terminal, failure then restart
    reset_dut();
    apb(1'b1, `MB_ADDR_CTRL, 32'h0000_0006);
    apb(1'b1, `MB_ADDR_TERM, 32'h0000_000A);
    pfail <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    `CHK("gate bound", 1'b0, gate_enable_o)
    pfail <= 1'b0;
    `WAITF(speed_search_o === 1'b1, 40)
    `CHK("speed search", 1'b1, speed_search_o)
    // Mode 2 with nothing bound: stop input gates the output
    reset_dut();
    apb(1'b1, `MB_ADDR_CTRL, 32'h0000_0002);
    repeat (8) @(posedge clk_sys_i);
    `CHK("gate stop low", 1'b0, gate_enable_o)
    output_stop_input_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    `CHK("gate stop high", 1'b1, gate_enable_o)
    $display("test enable done");
    // Programmed duty of 1 percent, alarm then trip
    reset_dut();
    apb(1'b1, `MB_ADDR_REGEN, 32'h0000_0301);
    apb(1'b1, `MB_ADDR_CTRL, 32'h0000_0001);
    apb(1'b1, `MB_ADDR_STATUS, 32'h001A_F587);
    repeat (3) @(posedge clk_sys_i);
    `CHK("idle terms", 3'b110, alarm_term_o)
    g0 = gate_enable_o;
    regen_req <= 1'b1;
    `WAITF(regen_duty_alarm_o === 1'b1, 30000)
    repeat (2) @(posedge clk_sys_i);
    `CHK("alarm", 2'b10, {regen_duty_alarm_o, regen_overvoltage_fault_o})
    `CHK("indicator", 1'b1, duty_panel_indicator_o)
    `CHK("alarm terms", 3'b001, alarm_term_o)
    `CHK("gate kept", g0, gate_enable_o)
    `WAITF(regen_overvoltage_fault_o === 1'b1, 10000)
    `CHK("fault", 1'b1, regen_overvoltage_fault_o)
    // Clear while still over the trip: the set must win
    apb(1'b1, `MB_ADDR_CTRL, 32'h0000_0009);
    repeat (2) @(posedge clk_sys_i);
    `CHK("set wins", 1'b1, regen_overvoltage_fault_o)
    regen_req <= 1'b0;
    repeat (300) @(posedge clk_sys_i);
    apb(1'b1, `MB_ADDR_CTRL, 32'h0000_0009);
    repeat (2) @(posedge clk_sys_i);
    `CHK("fault cleared", 1'b0, regen_overvoltage_fault_o)
    // Mode 0 ignores the zero limit and uses the fixed duty
    reset_dut();
    regen_req <= 1'b1;
    `WAITF(regen_duty_alarm_o === 1'b1, 50000)
    `CHK("fixed duty alarm", 1'b1, regen_duty_alarm_o)
    `CHK("no indicator", 1'b0, duty_panel_indicator_o)
    $display("test regen done");
    close_out();
  end
endmodule : motor_brake_stop_control_tb
`default_nettype wire
